// file: sbrg_pkg.sv
`default_nettype none
package sbrg_pkg;
   // ==========================================
   // register map, 8-bit data, one register per address
   localparam logic [2:0] ADDR_BAUD_CTRL = 3'h0;
   localparam logic [2:0] ADDR_DIV_LOW = 3'h1;
   localparam logic [2:0] ADDR_DIV_HIGH = 3'h2;
   localparam logic [2:0] ADDR_MODE = 3'h3;
   localparam logic [2:0] ADDR_INT_STAT = 3'h4;
   localparam logic [2:0] ADDR_INT_MASK = 3'h5;
   // baud_control fields
   localparam int BC_ABD_OVF = 7;
   localparam int BC_RX_IDLE = 6;
   localparam int BC_CLK_POL = 4;
   localparam int BC_WIDE = 3;
   localparam int BC_WAKE = 1;
   localparam int BC_ABD = 0;
   // mode register fields
   localparam int MODE_SYNC = 0;
   localparam int MODE_HS = 1;
   // interrupt status / mask fields
   localparam int INT_WAKE = 0;
   localparam int INT_ABD_DONE = 1;
   localparam int INT_ABD_OVF = 2;
   localparam int INT_W = 3;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_INT = 3'h0;
   // ==========================================
   // timing: prescaler tops (multiplier - 1) and shifts
   localparam logic [5:0] PRE_TOP_64 = 6'h3f;
   localparam logic [5:0] PRE_TOP_16 = 6'h0f;
   localparam logic [5:0] PRE_TOP_4 = 6'h03;
   localparam logic [4:0] MULT_SH_64 = 5'h06;
   localparam logic [4:0] MULT_SH_16 = 5'h04;
   localparam logic [4:0] MULT_SH_4 = 5'h02;
   // auto-baud: 8 bit times measured, four falls after the start fall
   localparam logic [4:0] ABD_BITS_SH = 5'h03;
   localparam logic [2:0] ABD_FALLS = 3'h4;
   localparam int ABD_CW = 25;
   // ==========================================
   typedef enum logic [1:0] {MULT_64, MULT_16, MULT_4} sbrg_mult_t;
   typedef enum logic [1:0] {ABD_IDLE, ABD_WAIT, ABD_MEASURE} sbrg_abd_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } sbrg_bus_t;
   typedef struct packed {
      logic [5:0] pre;
      logic [15:0] count;
      logic tick;
   } sbrg_tmr_t;
   typedef struct packed {
      logic clk_pol;
      logic wide;
      logic wake_en;
      logic abd_en;
      logic abd_ovf;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic sync;
      logic hs;
      logic [INT_W-1:0] int_stat;
      logic [INT_W-1:0] int_mask;
      logic [7:0] rdata;
      sbrg_abd_t abd_state;
      logic [ABD_CW-1:0] abd_cnt;
      logic [2:0] abd_falls;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      logic wake_pulse;
   } sbrg_state_t;
endpackage : sbrg_pkg
`default_nettype wire

// file: sbrg_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sbrg_timer (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_clear,
   input wire sbrg_pkg::sbrg_mult_t i_mult,
   input wire logic i_wide,
   input wire logic [15:0] i_divisor,
   output logic o_tick
);
   import sbrg_pkg::*;
   sbrg_tmr_t st_r, st_nxt;
   logic [5:0] pre_top;
   logic [4:0] mult_sh;
   logic hit;

   // ==========================================
   // prescaler then n+1 step counter
   always_comb begin
      case (i_mult)
         MULT_64: begin pre_top = PRE_TOP_64; mult_sh = MULT_SH_64; end
         MULT_16: begin pre_top = PRE_TOP_16; mult_sh = MULT_SH_16; end
         MULT_4: begin pre_top = PRE_TOP_4; mult_sh = MULT_SH_4; end
         default: begin pre_top = PRE_TOP_64; mult_sh = MULT_SH_64; end
      endcase
   end

   // narrow mode compares only the low byte
   assign hit = i_wide ? (st_r.count == i_divisor) : (st_r.count[7:0] == i_divisor[7:0]); // R1 R2 R6

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (i_clear) begin
         st_nxt.pre = 6'h00; // R7
         st_nxt.count = 16'h0000; // R7
      end else if (st_r.pre == pre_top) begin
         st_nxt.pre = 6'h00;
         if (hit) begin
            st_nxt.count = 16'h0000; // R3
            st_nxt.tick = 1'b1;
         end else if (i_wide) begin
            st_nxt.count = st_r.count + 16'h0001;
         end else begin
            st_nxt.count = {8'h00, st_r.count[7:0] + 8'h01};
         end
      end else begin
         st_nxt.pre = st_r.pre + 6'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_tick = st_r.tick;

   // ==========================================
   // checking helpers: cycles since last tick or clear
   logic [23:0] gap_r, exp_per;
   logic gap_ok_r;
   logic [16:0] prev_cfg_r;
   logic [15:0] prev_div_r;
   // a clear loads the new divisor one edge late; do not count that as a change
   logic clr_d_r;
   assign exp_per = ({8'h00, (i_wide ? i_divisor : {8'h00, i_divisor[7:0]})} + 24'h000001) << mult_sh;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gap_r <= 24'h000000;
         gap_ok_r <= 1'b0;
         prev_cfg_r <= 17'h00000;
         prev_div_r <= 16'h0000;
         clr_d_r <= 1'b0;
      end else begin
         prev_cfg_r <= {14'h0000, i_mult, i_wide};
         prev_div_r <= i_divisor;
         clr_d_r <= i_clear;
         if (i_clear || st_nxt.tick) begin
            gap_r <= 24'h000001;
            gap_ok_r <= i_clear || gap_ok_r;
         end else begin
            gap_r <= gap_r + 24'h000001;
         end
         if (!i_clear && !clr_d_r && ((prev_cfg_r != {14'h0000, i_mult, i_wide}) || (prev_div_r != i_divisor))) begin
            gap_ok_r <= 1'b0;
         end
      end
   end

   property p_tick_period;
      @(posedge i_clk) disable iff (!i_rst_b)
         (st_nxt.tick && gap_ok_r) |-> (gap_r == exp_per);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("baud period is not m*(n+1)"); // R3

   property p_clear_restart;
      @(posedge i_clk) disable iff (!i_rst_b)
         i_clear |=> !o_tick [*3];
   endproperty
   a_clear_restart: assert property (p_clear_restart) else $error("tick too soon after clear"); // R7
endmodule : sbrg_timer
`default_nettype wire

// file: sbrg_top.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: one baud timer, 8 or 16 bit
// R2: narrow after reset, wide while select set
// R3: free running, period n plus one
// R4: async multiplier 64, 16 or 4
// R5: sync ignores high speed, divides by four
// R6: divisor is high and low pair
// R7: divisor write clears the timer
// R8: software checks receive idle before clock change
// R9: auto-baud runs in async, self clears
// R10: wide divider reaches slow rates
// R11: wake edge sets flag, clears enable
module sbrg_top (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire sbrg_pkg::sbrg_bus_t i_bus,
   input wire logic i_rx,
   input wire logic i_receive_idle_flag,
   output logic [7:0] o_rdata,
   output logic o_baud_tick,
   output logic o_receive_int_flag_set,
   output logic o_clk_pol,
   output logic o_sync_mode,
   output logic o_irq
);
   import sbrg_pkg::*;

   sbrg_state_t st_r, st_nxt;
   sbrg_mult_t mult;
   logic [4:0] abd_sh;
   logic [ABD_CW-1:0] abd_q;
   logic [15:0] abd_n;
   logic abd_fits;
   logic fall;
   logic div_wr;
   logic abd_load;
   logic timer_clear;
   logic [INT_W-1:0] ev;

   // ==========================================
   // multiplier select
   always_comb begin
      if (st_r.sync) begin
         mult = MULT_4; // R5
      end else begin
         case ({st_r.hs, st_r.wide})
            2'b00: mult = MULT_64; // R4
            2'b11: mult = MULT_4; // R4
            default: mult = MULT_16; // R4
         endcase
      end
   end

   // auto-baud result: measured clocks over 8 bit times
   always_comb begin
      case (mult)
         MULT_64: abd_sh = MULT_SH_64 + ABD_BITS_SH;
         MULT_16: abd_sh = MULT_SH_16 + ABD_BITS_SH;
         MULT_4: abd_sh = MULT_SH_4 + ABD_BITS_SH;
         default: abd_sh = MULT_SH_64 + ABD_BITS_SH;
      endcase
   end
   assign abd_q = st_r.abd_cnt >> abd_sh;
   assign abd_n = abd_q[15:0] - 16'h0001;
   // narrow width only holds a byte; a wide divisor reaches slow rates
   assign abd_fits = (abd_q != '0) && (st_r.wide ? (abd_q[ABD_CW-1:16] == '0) : (abd_q[ABD_CW-1:8] == '0)); // R10

   // edge detect reads the second sync stage and its delayed copy only
   assign fall = st_r.rx_prev & ~st_r.rx_s2;
   assign div_wr = i_bus.wr && ((i_bus.addr == ADDR_DIV_LOW) || (i_bus.addr == ADDR_DIV_HIGH));

   // ==========================================
   // next state
   always_comb begin
      st_nxt = st_r;
      ev = RST_INT;
      abd_load = 1'b0;
      st_nxt.rdata = RST_BYTE;
      st_nxt.wake_pulse = 1'b0;
      // two-flop synchroniser on the pin, then edge stage
      st_nxt.rx_s1 = i_rx;
      st_nxt.rx_s2 = st_r.rx_s1;
      st_nxt.rx_prev = st_r.rx_s2;

      // wake on falling edge, async only
      if (st_r.wake_en && !st_r.sync && fall) begin
         st_nxt.wake_en = 1'b0; // R11
         st_nxt.wake_pulse = 1'b1; // R11
         ev[INT_WAKE] = 1'b1; // R11
      end

      // auto-baud measurement
      case (st_r.abd_state)
         ABD_IDLE: begin
            if (st_r.abd_en && !st_r.sync) begin
               st_nxt.abd_state = ABD_WAIT; // R9
            end
         end
         ABD_WAIT: begin
            if (!st_r.abd_en || st_r.sync) begin
               st_nxt.abd_state = ABD_IDLE; // R9
            end else if (fall) begin
               st_nxt.abd_state = ABD_MEASURE;
               st_nxt.abd_cnt = '0;
               st_nxt.abd_falls = 3'h0;
            end
         end
         ABD_MEASURE: begin
            st_nxt.abd_cnt = st_r.abd_cnt + 25'h0000001;
            if (!st_r.abd_en || st_r.sync) begin
               st_nxt.abd_state = ABD_IDLE; // R9
            end else if (fall && (st_r.abd_falls == ABD_FALLS - 3'h1)) begin
               st_nxt.abd_state = ABD_IDLE;
               st_nxt.abd_en = 1'b0; // R9
               if (abd_fits) begin
                  abd_load = 1'b1;
                  st_nxt.div_lo = abd_n[7:0];
                  st_nxt.div_hi = st_r.wide ? abd_n[15:8] : st_r.div_hi;
                  ev[INT_ABD_DONE] = 1'b1;
               end else begin
                  ev[INT_ABD_OVF] = 1'b1;
               end
            end else if (&st_r.abd_cnt) begin
               // counter would wrap: give up rather than report garbage
               st_nxt.abd_state = ABD_IDLE;
               st_nxt.abd_en = 1'b0; // R9
               ev[INT_ABD_OVF] = 1'b1;
            end else if (fall) begin
               st_nxt.abd_falls = st_r.abd_falls + 3'h1;
            end
         end
         default: st_nxt.abd_state = ABD_IDLE;
      endcase

      // software writes override hardware clears of control bits
      if (i_bus.wr) begin
         case (i_bus.addr)
            ADDR_BAUD_CTRL: begin
               st_nxt.clk_pol = i_bus.wdata[BC_CLK_POL];
               st_nxt.wide = i_bus.wdata[BC_WIDE]; // R2
               st_nxt.wake_en = i_bus.wdata[BC_WAKE];
               st_nxt.abd_en = i_bus.wdata[BC_ABD];
               st_nxt.abd_ovf = st_r.abd_ovf & i_bus.wdata[BC_ABD_OVF];
            end
            ADDR_DIV_LOW: st_nxt.div_lo = i_bus.wdata; // R6
            ADDR_DIV_HIGH: st_nxt.div_hi = i_bus.wdata; // R6
            ADDR_MODE: begin
               st_nxt.sync = i_bus.wdata[MODE_SYNC];
               st_nxt.hs = i_bus.wdata[MODE_HS];
            end
            ADDR_INT_MASK: st_nxt.int_mask = i_bus.wdata[INT_W-1:0];
            default: ;
         endcase
      end

      // reads: data in the following cycle, status clears on read
      if (i_bus.rd) begin
         case (i_bus.addr)
            ADDR_BAUD_CTRL: begin
               st_nxt.rdata[BC_ABD_OVF] = st_r.abd_ovf;
               st_nxt.rdata[BC_RX_IDLE] = i_receive_idle_flag;
               st_nxt.rdata[BC_CLK_POL] = st_r.clk_pol;
               st_nxt.rdata[BC_WIDE] = st_r.wide;
               st_nxt.rdata[BC_WAKE] = st_r.wake_en;
               st_nxt.rdata[BC_ABD] = st_r.abd_en;
            end
            ADDR_DIV_LOW: st_nxt.rdata = st_r.div_lo;
            ADDR_DIV_HIGH: st_nxt.rdata = st_r.div_hi;
            ADDR_MODE: begin
               st_nxt.rdata[MODE_SYNC] = st_r.sync;
               st_nxt.rdata[MODE_HS] = st_r.hs;
            end
            ADDR_INT_STAT: begin
               st_nxt.rdata[INT_W-1:0] = st_r.int_stat;
               st_nxt.int_stat = RST_INT;
            end
            ADDR_INT_MASK: st_nxt.rdata[INT_W-1:0] = st_r.int_mask;
            default: st_nxt.rdata = RST_BYTE;
         endcase
      end

      // hardware sets win over read-clear and write-clear
      st_nxt.int_stat = st_nxt.int_stat | ev;
      if (ev[INT_ABD_OVF]) begin
         st_nxt.abd_ovf = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0; // R2
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // baud timer; a new divisor restarts it at once
   assign timer_clear = div_wr || abd_load; // R7

   sbrg_timer u_timer (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_clear(timer_clear),
      .i_mult(mult),
      .i_wide(st_r.wide),
      .i_divisor({st_r.div_hi, st_r.div_lo}),
      .o_tick(o_baud_tick)
   ); // R1 R3 R6

   // outputs
   assign o_rdata = st_r.rdata;
   assign o_receive_int_flag_set = st_r.wake_pulse;
   assign o_clk_pol = st_r.clk_pol;
   assign o_sync_mode = st_r.sync;
   assign o_irq = |(st_r.int_stat & st_r.int_mask);

   // ==========================================
   // checks
   logic ctrl_touched_r;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_touched_r <= 1'b0;
      end else if (i_bus.wr && (i_bus.addr == ADDR_BAUD_CTRL)) begin
         ctrl_touched_r <= 1'b1;
      end
   end

   property p_reset_narrow;
      @(posedge i_clk) disable iff (!i_rst_b)
         !ctrl_touched_r |-> !st_r.wide;
   endproperty
   a_reset_narrow: assert property (p_reset_narrow) else $error("wide mode without a write"); // R2

   property p_async_mult;
      @(posedge i_clk) disable iff (!i_rst_b)
         !st_r.sync |-> (mult == ((st_r.hs == st_r.wide) ? (st_r.hs ? MULT_4 : MULT_64) : MULT_16));
   endproperty
   a_async_mult: assert property (p_async_mult) else $error("async multiplier wrong"); // R4

   property p_sync_mult;
      @(posedge i_clk) disable iff (!i_rst_b)
         st_r.sync |-> (mult == MULT_4);
   endproperty
   a_sync_mult: assert property (p_sync_mult) else $error("sync multiplier not four"); // R5

   property p_div_high;
      @(posedge i_clk) disable iff (!i_rst_b)
         (i_bus.wr && (i_bus.addr == ADDR_DIV_HIGH) && !abd_load) |=> (st_r.div_hi == $past(i_bus.wdata));
   endproperty
   a_div_high: assert property (p_div_high) else $error("divisor high not stored"); // R6

   property p_div_clear;
      @(posedge i_clk) disable iff (!i_rst_b)
         div_wr |=> !o_baud_tick [*3];
   endproperty
   a_div_clear: assert property (p_div_clear) else $error("tick soon after divisor write"); // R7

   property p_abd_sync_idle;
      @(posedge i_clk) disable iff (!i_rst_b)
         (st_r.sync && (st_r.abd_state == ABD_IDLE)) |=> (st_r.abd_state == ABD_IDLE);
   endproperty
   a_abd_sync_idle: assert property (p_abd_sync_idle) else $error("auto-baud ran in sync mode"); // R9

   sequence s_abd_end;
      (st_r.abd_state == ABD_MEASURE) && (ev[INT_ABD_DONE] || ev[INT_ABD_OVF]) && !i_bus.wr;
   endsequence
   property p_abd_selfclear;
      @(posedge i_clk) disable iff (!i_rst_b)
         s_abd_end |=> !st_r.abd_en && (st_r.abd_state == ABD_IDLE) ##1 !st_r.abd_en || ctrl_touched_r;
   endproperty
   a_abd_selfclear: assert property (p_abd_selfclear) else $error("auto-baud enable not cleared"); // R9

   sequence s_wake_edge;
      st_r.wake_en && !st_r.sync && fall && !i_bus.wr;
   endsequence
   property p_wake;
      @(posedge i_clk) disable iff (!i_rst_b)
         s_wake_edge |=> o_receive_int_flag_set && st_r.int_stat[INT_WAKE] && !st_r.wake_en;
   endproperty
   a_wake: assert property (p_wake) else $error("wake edge not handled"); // R11
endmodule : sbrg_top
`default_nettype wire

// file: test_serial_baud_rate_generator.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_baud_rate_generator;
   import sbrg_pkg::*;
   logic i_clk;
   logic i_rst_b;
   logic i_rx;
   logic idle;
   sbrg_bus_t bus;
   logic [7:0] rdata;
   logic tick;
   logic wake_set;
   logic clk_pol;
   logic sync_mode;
   logic irq;
   int errors;
   int checks;
   int pulses;
   int m;
   int n;

   sbrg_top sbrg_top_inst (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_bus(bus),
      .i_rx(i_rx),
      .i_receive_idle_flag(idle),
      .o_rdata(rdata),
      .o_baud_tick(tick),
      .o_receive_int_flag_set(wake_set),
      .o_clk_pol(clk_pol),
      .o_sync_mode(sync_mode),
      .o_irq(irq)
   );

   // ==========================================
   // clock, 50 MHz
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // ==========================================
   // shared tasks
   task automatic stop_test;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : compare

   // one-cycle write strobe, taken at the second edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask : wr

   // read data only stand in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1;
      compare({8'h00, rdata}, {8'h00, exp});
   endtask : rd

   // edges from the clearing write (or last tick) to the next tick
   task automatic measure(input int exp);
      int cnt;
      cnt = 0;
      do begin
         @(posedge i_clk);
         #1;
         cnt++;
      end while (tick !== 1'b1 && cnt < exp + 20);
      compare(16'(cnt), 16'(exp));
   endtask : measure

   // start bit, lsb first data, stop bit; t clocks per bit
   task automatic send_byte(input logic [7:0] b, input int t);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         i_rx <= frame[i];
         repeat (t - 1) @(posedge i_clk);
      end
   endtask : send_byte

   // pull the line low for a while and count wake pulses
   task automatic wake_try(output int cnt);
      cnt = 0;
      @(posedge i_clk);
      i_rx <= 1'b0;
      repeat (8) begin
         @(posedge i_clk);
         #1;
         if (wake_set === 1'b1) cnt++;
      end
      @(posedge i_clk);
      i_rx <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask : wake_try

   // ==========================================
   // watchdog, well beyond the longest expected run
   initial begin
      #(20 * 90000);
      errors++;
      stop_test();
   end

   // ==========================================
   // main sequence
   initial begin
      i_rst_b = 1'b0;
      i_rx = 1'b1;
      idle = 1'b0;
      bus = '0;
      errors = 0;
      checks = 0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;

      // everything reads zero after reset, unmapped too
      for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
      compare({15'h0, irq}, 16'h0);

      // register access and stored-only bits
      idle <= 1'b1;
      wr(ADDR_BAUD_CTRL, 8'hff);
      rd(ADDR_BAUD_CTRL, 8'h5b);
      compare({15'h0, clk_pol}, 16'h1);
      wr(ADDR_BAUD_CTRL, 8'h00);
      rd(ADDR_BAUD_CTRL, 8'h40);
      wr(ADDR_MODE, 8'h03);
      rd(ADDR_MODE, 8'h03);
      compare({15'h0, sync_mode}, 16'h1);
      wr(3'h7, 8'h5a);
      rd(3'h7, 8'h00);
      rd(3'h6, 8'h00);
      wr(ADDR_INT_MASK, 8'h07);
      rd(ADDR_INT_MASK, 8'h07);

      // every mode combination; high byte written last must restart the count
      for (int i = 0; i < 8; i++) begin
         m = (i[0] || (i[1] && i[2])) ? 4 : ((i[1] || i[2]) ? 16 : 64);
         n = i[2] ? 258 : 2;
         wr(ADDR_MODE, {6'h00, i[1], i[0]});
         wr(ADDR_BAUD_CTRL, {4'h0, i[2], 3'h0});
         wr(ADDR_DIV_LOW, 8'h02);
         wr(ADDR_DIV_HIGH, 8'h01);
         measure(m * (n + 1));
         measure(m * (n + 1));
         measure(m * (n + 1));
      end

      // auto-baud in async wide mode, multiplier 16, bit time 104
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_BAUD_CTRL, 8'h09);
      send_byte(8'h55, 104);
      repeat (4) @(posedge i_clk);
      rd(ADDR_BAUD_CTRL, 8'h48);
      rd(ADDR_DIV_LOW, 8'h05);
      rd(ADDR_DIV_HIGH, 8'h00);
      compare({15'h0, irq}, 16'h1);
      rd(ADDR_INT_STAT, 8'h02);
      rd(ADDR_INT_STAT, 8'h00);
      compare({15'h0, irq}, 16'h0);
      // the loaded divisor now sets the period; rewrite restarts the count
      wr(ADDR_DIV_HIGH, 8'h00);
      measure(16 * 6);

      // bit time too short for multiplier 64: result zero, overflow flagged
      wr(ADDR_BAUD_CTRL, 8'h01);
      send_byte(8'h55, 8);
      repeat (4) @(posedge i_clk);
      rd(ADDR_BAUD_CTRL, 8'hc0);
      rd(ADDR_INT_STAT, 8'h04);
      rd(ADDR_DIV_LOW, 8'h05);

      // wake on falling edge, async
      wr(ADDR_BAUD_CTRL, 8'h02);
      wake_try(pulses);
      compare(16'(pulses), 16'h1);
      compare({15'h0, irq}, 16'h1);
      rd(ADDR_BAUD_CTRL, 8'h40);
      rd(ADDR_INT_STAT, 8'h01);
      compare({15'h0, irq}, 16'h0);

      // masked wake: status sticks, no interrupt
      wr(ADDR_INT_MASK, 8'h00);
      wr(ADDR_BAUD_CTRL, 8'h02);
      wake_try(pulses);
      compare(16'(pulses), 16'h1);
      compare({15'h0, irq}, 16'h0);
      rd(ADDR_INT_STAT, 8'h01);
      wr(ADDR_INT_MASK, 8'h07);

      // sync mode ignores wake and auto-baud
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_BAUD_CTRL, 8'h03);
      wake_try(pulses);
      compare(16'(pulses), 16'h0);
      rd(ADDR_BAUD_CTRL, 8'h43);
      rd(ADDR_INT_STAT, 8'h00);

      // second reset in mid-run
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      // timer runs from release at the reset multiplier of 64
      measure(64);
      rd(ADDR_DIV_LOW, 8'h00);
      rd(ADDR_BAUD_CTRL, 8'h40);
      stop_test();
   end
endmodule : test_serial_baud_rate_generator
`default_nettype wire
